//--- hw/usart_core.sv
// serial transceiver core: clocking, framing, AHB-Lite registers
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "usart_params.svh"
module usart_core (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    input  wire logic        xfer_clock_in,
    output logic             xfer_clock_out,
    output logic             xfer_clock_oe
);
    // ==========================================================
    // declarations
    usart_pkg::cfg_t  cfg;
    usart_pkg::cfg_t  next_cfg;
    usart_pkg::edge_t slave_edges;
    logic [11:0] baud;
    logic [11:0] next_baud;
    logic        baud_reload;
    logic        tick;
    logic        d_wr, next_d_wr, d_rd, next_d_rd, rd_done, next_rd_done;
    logic [3:0]  d_addr, next_d_addr;
    logic [31:0] next_hrdata;
    logic        ap;
    logic [8:0]  tx_buf, next_tx_buf;
    logic        tx_full, next_tx_full;
    logic        tx_complete_flag, next_txc, rx_complete_flag, next_rxc, fe, next_fe, pe, next_pe;
    logic [8:0]  rx_data, next_rx_data;
    logic [3:0]  nbits;
    logic        pen;
    logic [4:0]  ovs;
    logic        rin1, rin2;
    logic [4:0]  tx_pre, next_tx_pre;
    logic        xck_int, next_xck_int, master_run;
    logic        chg_edge, smp_edge, tx_strobe, tx_active;
    logic [12:0] tx_frame, tx_shift, next_tx_shift;
    logic [3:0]  tx_len, tx_left, next_tx_left;
    logic        tx_par, tx_load, tx_done;
    logic [8:0]  tx_mask;
    usart_pkg::rx_state_t rx_state, next_rx_state;
    logic [4:0]  rx_cnt, next_rx_cnt;
    logic [3:0]  rx_idx, next_rx_idx, rx_last;
    logic [8:0]  rx_shift, next_rx_shift;
    logic        rx_pbit, next_rx_pbit, rx_strobe, rx_store;

    // ==========================================================
    // frame format, shared by both directions
    always_comb begin
        if (cfg.char_size_field == `CSZ_NINE) begin
            nbits = 4'h9;
        end else if (cfg.char_size_field[2]) begin
            nbits = 4'h8;
        end else begin
            nbits = {2'h0, cfg.char_size_field[1:0]} + 4'h5;
        end
    end
    assign pen = cfg.parity_mode_field[1];
    // sync mode never sees the double-speed bit
    assign ovs = (cfg.double_speed_sel && !cfg.sync_mode_sel_bit) ?
                 `OVS_DOUBLE : `OVS_NORMAL;

    // ==========================================================
    // clock generation
    baud_gen #(.DIV_W(12)) u_baud (
        .hclk    (hclk),
        .hresetn (hresetn),
        .divisor (next_baud),
        .reload  (baud_reload),
        .tick    (tick)
    );
    xck_sync u_xck (
        .hclk    (hclk),
        .hresetn (hresetn),
        .xck_in  (xfer_clock_in),
        .edges   (slave_edges)
    );

    assign master_run = cfg.sync_mode_sel_bit && cfg.xfer_clock_dir_bit &&
                        (cfg.tx_enable_bit || cfg.rx_enable_bit);
    always_comb begin
        next_tx_pre  = tx_pre;
        next_xck_int = xck_int;
        if (tick) begin
            next_tx_pre = (tx_pre == ovs - 5'h01) ? 5'h00 : tx_pre + 5'h01;
            if (master_run) begin
                next_xck_int = ~xck_int;
            end
        end
        chg_edge = 1'h0;
        smp_edge = 1'h0;
        if (cfg.sync_mode_sel_bit && cfg.xfer_clock_dir_bit) begin
            chg_edge = master_run && tick && (xck_int == cfg.clock_polarity_sel);
            smp_edge = master_run && tick && (xck_int != cfg.clock_polarity_sel);
        end else if (cfg.sync_mode_sel_bit) begin
            chg_edge = cfg.clock_polarity_sel ? slave_edges.fall : slave_edges.rise;
            smp_edge = cfg.clock_polarity_sel ? slave_edges.rise : slave_edges.fall;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_pre  <= 5'h00;
            xck_int <= 1'h0;
            rin1    <= 1'h1;
            rin2    <= 1'h1;
        end else begin
            tx_pre  <= next_tx_pre;
            xck_int <= next_xck_int;
            rin1    <= serial_in_pin;
            rin2    <= rin1;
        end
    end

    // master drives the clock pin while transmit or receive is enabled; slave leaves it as an input
    assign xfer_clock_out = xck_int;
    assign xfer_clock_oe  = master_run;

    // ==========================================================
    // transmitter
    assign tx_strobe = cfg.sync_mode_sel_bit ? chg_edge :
                       (tick && tx_pre == ovs - 5'h01);
    // disabling only bites once the shifter and buffer have drained
    assign tx_active = cfg.tx_enable_bit || (tx_left != 4'h0) || tx_full;
    assign tx_mask   = 9'h1FF >> (4'h9 - nbits);
    assign tx_par    = (^(tx_buf & tx_mask)) ^ cfg.parity_mode_field[0];
    assign tx_len    = 4'h2 + nbits + {3'h0, pen} + {3'h0, cfg.stop_count_sel};

    always_comb begin
        tx_frame    = 13'h1FFF;
        tx_frame[0] = 1'h0;
        for (int i = 0; i < 9; i++) begin
            if (i < nbits) begin
                tx_frame[i + 1] = tx_buf[i];
            end
        end
        if (pen) begin
            tx_frame[nbits + 4'h1] = tx_par;
        end
    end

    always_comb begin
        next_tx_shift = tx_shift;
        next_tx_left  = tx_left;
        tx_load       = 1'h0;
        tx_done       = 1'h0;
        if (tx_strobe && tx_active) begin
            if (tx_left <= 4'h1) begin
                tx_done = (tx_left == 4'h1) && !tx_full;
                if (tx_full) begin
                    tx_load       = 1'h1;
                    next_tx_shift = tx_frame;
                    next_tx_left  = tx_len;
                end else begin
                    next_tx_left  = 4'h0;
                end
            end else begin
                next_tx_shift = {1'h1, tx_shift[12:1]};
                next_tx_left  = tx_left - 4'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_shift <= 13'h1FFF;
            tx_left  <= 4'h0;
        end else begin
            tx_shift <= next_tx_shift;
            tx_left  <= next_tx_left;
        end
    end

    assign serial_out_oe  = tx_active;
    assign serial_out_pin = (tx_left != 4'h0) ? tx_shift[0] : 1'h1;

    // ==========================================================
    // receiver
    assign rx_last   = nbits + {3'h0, pen} + 4'h1;
    assign rx_strobe = cfg.sync_mode_sel_bit ? smp_edge :
                       (tick && rx_cnt == (ovs >> 1));

    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt   = rx_cnt;
        next_rx_idx   = rx_idx;
        next_rx_shift = rx_shift;
        next_rx_pbit  = rx_pbit;
        rx_store      = 1'h0;
        if (!cfg.rx_enable_bit) begin
            next_rx_state = usart_pkg::RX_IDLE;
        end else begin
            case (rx_state)
                usart_pkg::RX_IDLE: begin
                    next_rx_shift = 9'h000;
                    if (!cfg.sync_mode_sel_bit && tick && !rin2) begin
                        next_rx_state = usart_pkg::RX_BUSY;
                        next_rx_cnt   = 5'h00;
                        next_rx_idx   = 4'h0;
                    end else if (cfg.sync_mode_sel_bit && smp_edge && !rin2) begin
                        next_rx_state = usart_pkg::RX_BUSY;
                        next_rx_idx   = 4'h1;
                    end
                end
                usart_pkg::RX_BUSY: begin
                    if (tick) begin
                        next_rx_cnt = (rx_cnt == ovs - 5'h01) ? 5'h00 : rx_cnt + 5'h01;
                    end
                    if (rx_strobe) begin
                        next_rx_idx = rx_idx + 4'h1;
                        if (rx_idx == 4'h0) begin
                            // a start bit gone high by mid-bit was noise
                            if (rin2) begin
                                next_rx_state = usart_pkg::RX_IDLE;
                            end
                        end else if (rx_idx <= nbits) begin
                            next_rx_shift[rx_idx - 4'h1] = rin2;
                        end else if (pen && rx_idx == nbits + 4'h1) begin
                            next_rx_pbit = rin2;
                        end
                        if (rx_idx == rx_last) begin
                            rx_store      = 1'h1;
                            next_rx_state = usart_pkg::RX_IDLE;
                        end
                    end
                end
                default: begin
                    next_rx_state = usart_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state <= usart_pkg::RX_IDLE;
            rx_cnt   <= 5'h00;
            rx_idx   <= 4'h0;
            rx_shift <= 9'h000;
            rx_pbit  <= 1'h0;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_idx   <= next_rx_idx;
            rx_shift <= next_rx_shift;
            rx_pbit  <= next_rx_pbit;
        end
    end

    // ==========================================================
    // AHB-Lite slave: writes zero-wait, reads one wait state
    assign ap          = hsel && htrans[1] && hready;
    assign hreadyout   = !d_rd || rd_done;
    assign hresp       = 1'h0;
    assign baud_reload = d_wr && d_addr == `OFS_BAUD;

    always_comb begin
        next_d_wr    = hreadyout ? (ap && hwrite) : d_wr;
        next_d_rd    = hreadyout ? (ap && !hwrite) : d_rd;
        next_d_addr  = (hreadyout && ap) ? haddr[3:0] : d_addr;
        next_rd_done = d_rd && !rd_done;
        next_hrdata  = hrdata;
        next_cfg     = cfg;
        next_baud    = baud;
        next_tx_buf  = tx_buf;
        next_tx_full = tx_full && !tx_load;
        next_txc     = tx_complete_flag;
        next_rxc     = rx_complete_flag;
        next_fe      = fe;
        next_pe      = pe;
        next_rx_data = rx_data;
        if (d_wr) begin
            if (d_addr == `OFS_CTRL) begin
                next_cfg = hwdata[11:0];
            end else if (d_addr == `OFS_STATUS) begin
                if (hwdata[`ST_TXC]) begin
                    next_txc = 1'h0;
                end
            end else if (d_addr == `OFS_DATA) begin
                if (!tx_full) begin
                    next_tx_buf  = hwdata[8:0];
                    next_tx_full = 1'h1;
                end
            end else if (d_addr == `OFS_BAUD) begin
                next_baud = hwdata[11:0];
            end
        end
        if (d_rd && !rd_done) begin
            if (d_addr == `OFS_CTRL) begin
                next_hrdata = {20'h00000, cfg};
            end else if (d_addr == `OFS_STATUS) begin
                next_hrdata = {27'h0000000, !tx_full, pe, fe, tx_complete_flag, rx_complete_flag};
            end else if (d_addr == `OFS_DATA) begin
                next_hrdata = {23'h000000, rx_data};
                next_rxc    = 1'h0;
            end else if (d_addr == `OFS_BAUD) begin
                next_hrdata = {20'h00000, baud};
            end else begin
                next_hrdata = 32'h00000000;
            end
        end
        // hardware events win over a same-cycle clear
        if (tx_done) begin
            next_txc = 1'h1;
        end
        if (rx_store) begin
            next_rxc     = 1'h1;
            next_rx_data = rx_shift;
            next_fe      = !rin2;
            next_pe      = pen && ((^rx_shift) ^ cfg.parity_mode_field[0] ^ rx_pbit);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_wr    <= 1'h0;
            d_rd    <= 1'h0;
            rd_done <= 1'h0;
            d_addr  <= 4'h0;
            hrdata  <= 32'h00000000;
            cfg     <= `CTRL_RESET;
            baud    <= `BAUD_RESET;
            tx_buf  <= 9'h000;
            tx_full <= 1'h0;
            tx_complete_flag     <= 1'h0;
            rx_complete_flag     <= 1'h0;
            fe      <= 1'h0;
            pe      <= 1'h0;
            rx_data <= 9'h000;
        end else begin
            d_wr    <= next_d_wr;
            d_rd    <= next_d_rd;
            rd_done <= next_rd_done;
            d_addr  <= next_d_addr;
            hrdata  <= next_hrdata;
            cfg     <= next_cfg;
            baud    <= next_baud;
            tx_buf  <= next_tx_buf;
            tx_full <= next_tx_full;
            tx_complete_flag     <= next_txc;
            rx_complete_flag     <= next_rxc;
            fe      <= next_fe;
            pe      <= next_pe;
            rx_data <= next_rx_data;
        end
    end

    // ==========================================================
    // checks
    chk_idle_line_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_left <= 4'h1) |-> serial_out_pin)
        else $error("idle line not high");
    chk_start_bit_low: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(tx_left) <= 4'h1 && tx_left == tx_len && $past(tx_load)) |-> !serial_out_pin)
        else $error("start bit not low");
    chk_txd_takeover: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_left != 4'h0) |-> serial_out_oe)
        else $error("serial output released mid frame");
    chk_slave_no_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cfg.xfer_clock_dir_bit || !cfg.sync_mode_sel_bit) |-> !xfer_clock_oe)
        else $error("clock pin driven outside master mode");
    chk_async_bit_div: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_strobe && !cfg.sync_mode_sel_bit) |-> tick ##1 (tx_pre == 5'h00))
        else $error("async transmit divider wrong");
    chk_frame_err: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_store |=> (rx_complete_flag && fe == !$past(rin2)))
        else $error("frame error not tied to first stop bit");
    chk_txc_set: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_done |=> tx_complete_flag)
        else $error("transmit complete lost");
    chk_sync_edges: assert property (@(posedge hclk) disable iff (!hresetn)
        !(chg_edge && smp_edge))
        else $error("change and sample on one edge");
endmodule : usart_core
`default_nettype wire

//--- hw/usart_params.svh
// offsets, field positions, reset values and divider figures of the serial block
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH
`define OFS_CTRL     4'h0
`define OFS_STATUS   4'h4
`define OFS_DATA     4'h8
`define OFS_BAUD     4'hC
`define ST_RXC       0
`define ST_TXC       1
`define ST_FE        2
`define ST_PE        3
`define ST_EMPTY     4
`define CTRL_RESET   12'h0C0
`define BAUD_RESET   12'h000
`define OVS_NORMAL   5'h10
`define OVS_DOUBLE   5'h08
`define CSZ_NINE     3'h7
`endif

//--- hw/usart_pkg.sv
// shared types of the serial block
package usart_pkg;
    typedef struct packed {
        logic       stop_count_sel;
        logic [1:0] parity_mode_field;
        logic [2:0] char_size_field;
        logic       clock_polarity_sel;
        logic       xfer_clock_dir_bit;
        logic       sync_mode_sel_bit;
        logic       double_speed_sel;
        logic       rx_enable_bit;
        logic       tx_enable_bit;
    } cfg_t;
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_t;
    typedef enum logic {RX_IDLE, RX_BUSY} rx_state_t;
endpackage : usart_pkg

//--- hw/baud_gen.sv
// down-counting baud generator
`timescale 1ns/1ps
`default_nettype none
module baud_gen #(
    parameter int DIV_W = 12
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             reload,
    output logic                  tick
);
    generate
        if (DIV_W < 2 || DIV_W > 16) begin : g_bad
            $error("baud_gen: DIV_W out of range");
        end
    endgenerate

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;

    assign tick = (cnt == '0);

    always_comb begin
        if (reload || tick) begin
            next_cnt = divisor;
        end else begin
            next_cnt = cnt - 1'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    chk_baud_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick || reload) |=> cnt == $past(divisor))
        else $error("baud counter did not reload");
endmodule : baud_gen
`default_nettype wire

//--- hw/xck_sync.sv
// transfer clock synchroniser and edge detector for slave mode
`timescale 1ns/1ps
`default_nettype none
module xck_sync (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    input  wire logic   xck_in,
    output usart_pkg::edge_t edges
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
        end else begin
            s1 <= xck_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // one-cycle strobes, two clocks after the pin moves
    assign edges.rise = s2 & ~s3;
    assign edges.fall = ~s2 & s3;

    chk_edge_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        edges.rise |-> ($past(xck_in, 2) && !$past(xck_in, 3)))
        else $error("slave clock edge latency wrong");
endmodule : xck_sync
`default_nettype wire

//--- verif/remote_port.sv
// remote serial port: captures transmitted frames and sends frames
`timescale 1ns/1ps
`default_nettype none
module remote_port (
    input  wire logic hclk,
    input  wire logic line_in,
    output var logic  line_out,
    output var logic  clk_out
);
    // ==========
    // line access
    initial line_out = 1'b1;
    // the transfer clock rests low between frames
    initial clk_out = 1'b0;
    // samples each bit at its middle, start bit first
    task automatic get(input int n, input int bt, output logic [12:0] b);
        b = '0;
        @(negedge line_in);
        repeat (bt / 2) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            b[i] = line_in;
            repeat (bt) @(posedge hclk);
        end
    endtask : get
    task automatic put(input logic [12:0] b, input int n, input int bt);
        for (int i = 0; i < n; i++) begin
            line_out <= b[i];
            repeat (bt) @(posedge hclk);
        end
        line_out <= 1'b1;
    endtask : put
    // sync slave frame, polarity clear: one extra period lets the far transmitter finish
    task automatic xfer(input logic [12:0] b, input int n, input int hp,
                        output logic [12:0] g);
        g = '0;
        for (int i = 0; i <= n; i++) begin
            clk_out  <= 1'b1;
            line_out <= (i < n) ? b[i] : 1'b1;
            repeat (hp) @(posedge hclk);
            if (i < n) begin
                g[i] = line_in;
            end
            clk_out <= 1'b0;
            repeat (hp) @(posedge hclk);
        end
    endtask : xfer
endmodule : remote_port
`default_nettype wire

//--- verif/tb_usart_core.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module tb_usart_core;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        rx_line, tx_line, tx_oe, xck_in, xck_out, xck_oe;
    logic [12:0] fb, gb;
    logic [11:0] xv;
    int          nb;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    // formats: 8N1, 7E2 double speed, 5O1, 9E1 double speed; baud divisor 1
    logic [11:0] ctl [4] = '{12'h0C3, 12'hC87, 12'h603, 12'h5C7};
    logic [8:0]  dat [4] = '{9'h0A5, 9'h0F3, 9'h036, 9'h1C9};
    int          nds [4] = '{8, 7, 5, 9};
    int          pty [4] = '{0, 2, 3, 2};
    int          nss [4] = '{1, 2, 1, 1};
    int          bts [4] = '{32, 16, 32, 16};

    usart_core usart_core_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .serial_in_pin(rx_line), .serial_out_pin(tx_line), .serial_out_oe(tx_oe),
        .xfer_clock_in(xck_in), .xfer_clock_out(xck_out), .xfer_clock_oe(xck_oe)
    );
    remote_port remote_port_inst (.hclk(hclk), .line_in(tx_line), .line_out(rx_line),
                                  .clk_out(xck_in));

    // ==========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus
    // whole frame, start bit in bit 0
    function automatic void frm(input logic [8:0] d, input int nd, input int par,
                                input int ns, output logic [12:0] b, output int n);
        b = '0;
        for (int i = 0; i < nd; i++) b[i + 1] = d[i];
        n = nd + 1;
        if (par >= 2) begin
            b[n] = ^(d & 9'((1 << nd) - 1)) ^ (par == 3);
            n++;
        end
        for (int i = 0; i < ns; i++) b[n + i] = 1'b1;
        n = n + ns;
    endfunction : frm

    // ==========
    // clock, timeout, sequence
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk(rd, 32'h0C0);
        bus(1'b1, 32'hC, 32'h1, rd);
        bus(1'b0, 32'hC, 32'h0, rd);
        chk(rd, 32'h1);
        for (int k = 0; k < 4; k++) begin
            frm(dat[k], nds[k], pty[k], nss[k], fb, nb);
            bus(1'b1, 32'h0, {20'h0, ctl[k]}, rd);
            bus(1'b1, 32'h8, {23'h0, dat[k]}, rd);
            remote_port_inst.get(nb, bts[k], gb);
            chk({19'h0, gb}, {19'h0, fb});
            chk({30'h0, tx_oe, tx_line}, 32'h3);
            remote_port_inst.put(fb, nb, bts[k]);
            bus(1'b0, 32'h4, 32'h0, rd);
            chk({27'h0, rd[4:0]}, 32'h13);
            bus(1'b0, 32'h8, 32'h0, rd);
            chk(rd, {23'h0, dat[k] & 9'((1 << nds[k]) - 1)});
        end
        // writing one clears transmit complete
        bus(1'b1, 32'h4, 32'h2, rd);
        bus(1'b0, 32'h4, 32'h0, rd);
        chk(rd, 32'h10);
        // first stop bit low must raise the frame error flag
        frm(9'h1C9, 9, 2, 1, fb, nb);
        fb[nb - 1] = 1'b0;
        remote_port_inst.put(fb, nb, 16);
        bus(1'b0, 32'h4, 32'h0, rd);
        chk({31'h0, rd[2]}, 32'h1);
        // sync master with double speed set: clock period stays 2*(divisor+1)
        bus(1'b1, 32'h0, 32'h0DD, rd);
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 12; i++) begin
            @(negedge hclk);
            xv[i] = xck_out;
        end
        chk({22'h0, xv[11:2] ^ xv[9:0]}, 32'h3FF);
        chk({31'h0, xck_oe}, 32'h1);
        @(posedge hclk);
        bus(1'b1, 32'h0, 32'h0C9, rd);
        repeat (2) @(posedge hclk);
        chk({31'h0, xck_oe}, 32'h0);
        // sync slave: one 8N1 frame each way on the far side's clock, fclk/8
        frm(9'h05A, 8, 0, 1, fb, nb);
        bus(1'b1, 32'h0, 32'h0CB, rd);
        bus(1'b1, 32'h8, 32'h05A, rd);
        remote_port_inst.xfer(fb, nb, 4, gb);
        chk({19'h0, gb}, {19'h0, fb});
        bus(1'b0, 32'h4, 32'h0, rd);
        chk(rd, 32'h13);
        bus(1'b0, 32'h8, 32'h0, rd);
        chk(rd, 32'h05A);
        end_of_test();
    end
endmodule : tb_usart_core
`default_nettype wire
